/* design/srad_device.sv */
`timescale 1ns/10ps
module srad_device #(
  parameter int unsigned PUW_CYC = srad_pkg::PUW_MIN_CYC,
  parameter int unsigned ERASE_CYC = srad_pkg::ERASE_CYC,
  parameter int unsigned PROG_CYC = srad_pkg::PROG_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  srad_spi_if.device SPI,
  input wire logic [3:0] LOCK_SET,
  output logic BUSY,
  output logic WRITE_ENABLE_LATCH,
  output logic [3:0] LOCK_BITS
);
  logic [7:0] mem_q [srad_pkg::NUM_REGS][srad_pkg::REG_BYTES];
  logic sclk_q, cs_q;
  logic [5:0] cnt_q;
  logic [2:0] bitpos_q, obit_q;
  logic [7:0] in_sr_q, cmd_q, out_sr_q, off_q, nb;
  logic [15:0] addr_q;
  logic [23:0] full_addr;
  logic [1:0] sel_q;
  logic go_q, rd_q, stat_q, busy_q, write_enable_latch_q, erasing_q, so_q;
  logic [3:0] lock_q;
  logic [31:0] tmr_q, pu_cnt_q;
  logic [8:0] er_idx_q;
  logic rise, fall, cs_up, byte_done, pu_done, addr_ok, data_byte, erase_go, prog_go;

  // The far end runs on this clock, so its pins need no synchroniser.
  assign rise = SPI.sclk & ~sclk_q & ~SPI.cs_n;
  assign fall = ~SPI.sclk & sclk_q & ~SPI.cs_n;
  assign cs_up = SPI.cs_n & ~cs_q;
  assign byte_done = rise & (bitpos_q == 3'h7);
  assign nb = {in_sr_q[6:0], SPI.mosi};
  assign full_addr = {addr_q, nb};
  assign addr_ok = (full_addr[23:14] == 10'h000) && (full_addr[11:8] == 4'h0);
  assign data_byte = byte_done & (cnt_q >= (srad_pkg::BITS_DUMMY - 6'h01));
  assign pu_done = (pu_cnt_q >= PUW_CYC);
  // Erase needs select to rise exactly on the address boundary.
  assign erase_go = cs_up & go_q & (cmd_q == srad_pkg::CMD_ERASE)
    & (cnt_q == srad_pkg::BITS_ADDR) & (bitpos_q == 3'h0);
  assign prog_go = cs_up & go_q & (cmd_q == srad_pkg::CMD_PROG)
    & (cnt_q == srad_pkg::BITS_DUMMY) & (bitpos_q == 3'h0);

  // Edge history of the link pins.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sclk_q <= SPI.sclk;
      cs_q <= SPI.cs_n;
    end
  end

  // Power-up write wait; write commands are refused until it expires.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pu_cnt_q <= 32'h00000000;
    end else if (!pu_done) begin
      pu_cnt_q <= pu_cnt_q + 32'h00000001;
    end
  end

  // One-time lock bits only gain ones until reset clears them.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_q <= 4'h0;
    end else begin
      lock_q <= lock_q | LOCK_SET;
    end
  end

  // Input shifter: command, address and decode of the target.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_q <= 6'h00;
      bitpos_q <= 3'h0;
      in_sr_q <= 8'h00;
      cmd_q <= 8'h00;
      addr_q <= 16'h0000;
      sel_q <= 2'h0;
      go_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (SPI.cs_n) begin
      cnt_q <= 6'h00;
      bitpos_q <= 3'h0;
      go_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (rise) begin
      in_sr_q <= nb;
      bitpos_q <= bitpos_q + 3'h1;
      if (cnt_q != srad_pkg::BITS_DUMMY) begin
        cnt_q <= cnt_q + 6'h01;
      end
      if (byte_done && cnt_q == srad_pkg::BITS_CMD - 6'h01) begin
        cmd_q <= nb;
      end
      if (byte_done && cnt_q > srad_pkg::BITS_CMD - 6'h01 && cnt_q < srad_pkg::BITS_ADDR) begin
        addr_q <= full_addr[15:0];
      end
      if (byte_done && cnt_q == srad_pkg::BITS_ADDR - 6'h01) begin
        sel_q <= full_addr[13:12];
        go_q <= write_enable_latch_q && !busy_q && pu_done && addr_ok
          && !lock_q[full_addr[13:12]]
          && (cmd_q == srad_pkg::CMD_ERASE || cmd_q == srad_pkg::CMD_PROG);
        rd_q <= (cmd_q == srad_pkg::CMD_READ) && !busy_q && addr_ok;
      end
    end
  end

  // Self-timed cycle; the latch is cleared when it ends.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_q <= 1'b0;
      write_enable_latch_q <= 1'b0;
      erasing_q <= 1'b0;
      tmr_q <= 32'h00000000;
    end else if (busy_q) begin
      if (tmr_q == 32'h00000000) begin
        busy_q <= 1'b0;
        erasing_q <= 1'b0;
        write_enable_latch_q <= 1'b0;
      end else begin
        tmr_q <= tmr_q - 32'h00000001;
      end
    end else if (erase_go || prog_go) begin
      busy_q <= 1'b1;
      erasing_q <= erase_go;
      tmr_q <= erase_go ? ERASE_CYC - 32'h00000001 : PROG_CYC - 32'h00000001;
    end else if (cs_up && cmd_q == srad_pkg::CMD_WREN && cnt_q == srad_pkg::BITS_CMD && pu_done) begin
      write_enable_latch_q <= 1'b1;
    end
  end

  // Array: erase sweeps one byte a cycle, program only clears bits.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      er_idx_q <= 9'h000;
      for (int r = 0; r < srad_pkg::NUM_REGS; r++) begin
        for (int b = 0; b < srad_pkg::REG_BYTES; b++) begin
          mem_q[r][b] <= srad_pkg::ERASED;
        end
      end
    end else if (erase_go) begin
      er_idx_q <= 9'h000;
    end else if (erasing_q && !er_idx_q[8]) begin
      mem_q[sel_q][er_idx_q[7:0]] <= srad_pkg::ERASED;
      er_idx_q <= er_idx_q + 9'h001;
    end else if (data_byte && go_q && cmd_q == srad_pkg::CMD_PROG) begin
      mem_q[sel_q][off_q] <= mem_q[sel_q][off_q] & nb;
    end
  end

  // Output path: read data or status, shifted out on falling edges.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      off_q <= 8'h00;
      out_sr_q <= 8'h00;
      obit_q <= 3'h0;
      stat_q <= 1'b0;
      so_q <= 1'b1;
    end else if (SPI.cs_n) begin
      stat_q <= 1'b0;
      obit_q <= 3'h0;
    end else if (byte_done && cnt_q == srad_pkg::BITS_CMD - 6'h01 && nb == srad_pkg::CMD_RDSR) begin
      stat_q <= 1'b1;
      out_sr_q <= {2'b00, lock_q, write_enable_latch_q, busy_q};
    end else if (byte_done && cnt_q == srad_pkg::BITS_ADDR - 6'h01) begin
      off_q <= full_addr[7:0];
    end else if (data_byte && go_q && cmd_q == srad_pkg::CMD_PROG) begin
      off_q <= off_q + 8'h01;
    end else if (byte_done && rd_q && cnt_q == srad_pkg::BITS_DUMMY - 6'h01) begin
      out_sr_q <= mem_q[sel_q][off_q];
    end else if (fall && (stat_q || (rd_q && cnt_q == srad_pkg::BITS_DUMMY))) begin
      so_q <= out_sr_q[7];
      obit_q <= obit_q + 3'h1;
      if (obit_q != 3'h7) begin
        out_sr_q <= {out_sr_q[6:0], 1'b0};
      end else if (stat_q) begin
        out_sr_q <= {2'b00, lock_q, write_enable_latch_q, busy_q};
      end else begin
        out_sr_q <= mem_q[sel_q][off_q + 8'h01];
        off_q <= off_q + 8'h01;
      end
    end
  end

  // The data line is driven from the end of the command byte (status) or of the dummy byte (read) until select rises.
  assign SPI.miso_drv = so_q;
  assign SPI.miso_oe = ~SPI.cs_n & (stat_q | (rd_q & (cnt_q == srad_pkg::BITS_DUMMY)));
  assign BUSY = busy_q;
  assign WRITE_ENABLE_LATCH = write_enable_latch_q;
  assign LOCK_BITS = lock_q;
endmodule : srad_device

/* include/srad_pkg.sv */
// Notes on behaviour
// - Four separate 256-byte registers, individually writable.
// - Erase accepted only with write enable set.
// - Erase: select low, 44h, 24-bit address.
// - Register number from bits 13:12, rest zero; here bits 7:0 are not checked.
// - Erase runs only if select rises at boundary.
// - Self-timed erase holds busy; status still readable.
// - Erase completion clears the write enable latch.
// - Set lock bit forbids erase and program forever; here reset clears the lock bits.
// - Register 0 reserved; prefer registers 1 to 3.
// - Program: write enable, 42h, address, data bytes.
// - Program writes 1..256 bytes into erased locations.
// - Select stays low through all program data.
// - Read: 48h, address, eight dummy clocks, data.
// - Sample on rising edge, drive on falling, MSB first.
// - Read offset increments, wraps FFh to 00h.
// - Read ignored while busy.
// - No write commands before power-up write wait.
package srad_pkg;
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_RDSR = 8'h05;
  localparam logic [7:0] CMD_ERASE = 8'h44;
  localparam logic [7:0] CMD_PROG = 8'h42;
  localparam logic [7:0] CMD_READ = 8'h48;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam int unsigned NUM_REGS = 4;
  localparam int unsigned REG_BYTES = 256;
  // Bit counts since select fell: command, address end, dummy end.
  localparam logic [5:0] BITS_CMD = 6'h08;
  localparam logic [5:0] BITS_ADDR = 6'h20;
  localparam logic [5:0] BITS_DUMMY = 6'h28;
  // Status byte fields.
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_WR_LATCH = 1;
  localparam int unsigned ST_LOCK = 2;
  // Timing: times in microseconds, counts at 200 MHz.
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned PUW_MIN_US = 1000;
  localparam int unsigned PUW_MAX_US = 10000;
  localparam int unsigned ERASE_TIME_US = 1000;
  localparam int unsigned PROG_TIME_US = 100;
  localparam int unsigned PUW_MIN_CYC = PUW_MIN_US * CLK_MHZ;
  localparam int unsigned PUW_MAX_CYC = PUW_MAX_US * CLK_MHZ;
  localparam int unsigned ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam logic [2:0] SCK_HALF = 3'h4;
  // Controller register offsets and bits.
  localparam logic [7:0] OFS_TX = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RX = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam int unsigned TX_LAST = 8;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_REFUSED = 1;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOW = 2'b01,
    H_HIGH = 2'b10,
    H_TAIL = 2'b11
  } srad_host_state_e;
endpackage : srad_pkg

/* include/srad_spi_if.sv */
`timescale 1ns/10ps
// Serial link between controller and flash; idle data line reads high.
interface srad_spi_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso_drv;
  logic miso_oe;
  logic miso;
  assign miso = miso_oe ? miso_drv : 1'b1;
  modport host (output cs_n, output sclk, output mosi, input miso);
  modport device (input cs_n, input sclk, input mosi, output miso_drv, output miso_oe);
endinterface : srad_spi_if

/* design/srad_host.sv */
`timescale 1ns/10ps
module srad_host #(
  parameter int unsigned PUW_CYC = srad_pkg::PUW_MAX_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic IRQ,
  srad_spi_if.host SPI
);
  srad_pkg::srad_host_state_e st_q;
  logic wr_ph_q, rd_ph_q;
  logic [7:0] ofs_q, tx_q, rx_q;
  logic [31:0] hrdata_q, pu_cnt_q;
  logic [2:0] half_q, bit_q;
  logic [1:0] irq_stat_q, irq_mask_q, irq_set;
  logic last_q, cs_n_q, sclk_q, mosi_q, wen_sent_q, start, tick, pu_done, is_write_cmd;

  // Zero-wait slave: address phase latched, write lands in data phase.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      ofs_q <= 8'h00;
    end else if (HREADY) begin
      wr_ph_q <= HSEL & HTRANS[1] & HWRITE;
      rd_ph_q <= HSEL & HTRANS[1] & ~HWRITE;
      ofs_q <= HADDR[7:0];
    end
  end

  // Read data is registered so it stands for the whole data phase.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hrdata_q <= 32'h00000000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      case (HADDR[7:0])
        srad_pkg::OFS_STATUS: hrdata_q <= {29'h0, cs_n_q, pu_done, st_q != srad_pkg::H_IDLE};
        srad_pkg::OFS_RX: hrdata_q <= {24'h0, rx_q};
        srad_pkg::OFS_IRQ_STAT: hrdata_q <= {30'h0, irq_stat_q};
        srad_pkg::OFS_IRQ_MASK: hrdata_q <= {30'h0, irq_mask_q};
        default: hrdata_q <= 32'h00000000;
      endcase
    end
  end

  assign HRDATA = hrdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Write-type commands need the power-up wait and a prior write enable.
  assign is_write_cmd = (HWDATA[7:0] == srad_pkg::CMD_ERASE) || (HWDATA[7:0] == srad_pkg::CMD_PROG);
  assign start = wr_ph_q && ofs_q == srad_pkg::OFS_TX && st_q == srad_pkg::H_IDLE
    && !(cs_n_q && !pu_done && (is_write_cmd || HWDATA[7:0] == srad_pkg::CMD_WREN))
    && !(cs_n_q && is_write_cmd && !wen_sent_q);
  assign irq_set[srad_pkg::IRQ_REFUSED] = wr_ph_q && ofs_q == srad_pkg::OFS_TX && !start;
  assign pu_done = (pu_cnt_q >= PUW_CYC);
  assign tick = (half_q == srad_pkg::SCK_HALF - 3'h1);

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pu_cnt_q <= 32'h00000000;
    end else if (!pu_done) begin
      pu_cnt_q <= pu_cnt_q + 32'h00000001;
    end
  end

  // Remembers a one-byte write-enable frame until the next frame of any kind is started.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wen_sent_q <= 1'b0;
    end else if (start && cs_n_q) begin
      wen_sent_q <= (HWDATA[7:0] == srad_pkg::CMD_WREN) && HWDATA[srad_pkg::TX_LAST];
    end
  end

  // Byte engine: mode 0, MSB first, select held low between bytes.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= srad_pkg::H_IDLE;
      half_q <= 3'h0;
      bit_q <= 3'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      last_q <= 1'b0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
    end else begin
      half_q <= (st_q == srad_pkg::H_IDLE || tick) ? 3'h0 : half_q + 3'h1;
      case (st_q)
        srad_pkg::H_IDLE: begin
          if (start) begin
            cs_n_q <= 1'b0;
            tx_q <= HWDATA[7:0];
            last_q <= HWDATA[srad_pkg::TX_LAST];
            mosi_q <= HWDATA[7];
            bit_q <= 3'h0;
            st_q <= srad_pkg::H_LOW;
          end
        end
        srad_pkg::H_LOW: begin
          if (tick) begin
            sclk_q <= 1'b1;
            rx_q <= {rx_q[6:0], SPI.miso};
            st_q <= srad_pkg::H_HIGH;
          end
        end
        srad_pkg::H_HIGH: begin
          if (tick) begin
            sclk_q <= 1'b0;
            tx_q <= {tx_q[6:0], 1'b0};
            mosi_q <= tx_q[6];
            bit_q <= bit_q + 3'h1;
            if (bit_q != 3'h7) begin
              st_q <= srad_pkg::H_LOW;
            end else if (last_q) begin
              st_q <= srad_pkg::H_TAIL;
            end else begin
              st_q <= srad_pkg::H_IDLE;
            end
          end
        end
        srad_pkg::H_TAIL: begin
          if (tick) begin
            cs_n_q <= 1'b1;
            st_q <= srad_pkg::H_IDLE;
          end
        end
        default: st_q <= srad_pkg::H_IDLE;
      endcase
    end
  end

  assign irq_set[srad_pkg::IRQ_DONE] = (st_q == srad_pkg::H_HIGH && tick && bit_q == 3'h7 && !last_q)
    || (st_q == srad_pkg::H_TAIL && tick);

  // Sticky events: a new event beats a same-cycle write-one clear.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
    end else begin
      if (wr_ph_q && ofs_q == srad_pkg::OFS_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~HWDATA[1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      if (wr_ph_q && ofs_q == srad_pkg::OFS_IRQ_MASK) begin
        irq_mask_q <= HWDATA[1:0];
      end
    end
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);
  assign SPI.cs_n = cs_n_q;
  assign SPI.sclk = sclk_q;
  assign SPI.mosi = mosi_q;
endmodule : srad_host

/* test/srad_assertions.sv */
`timescale 1ns/10ps
// Watches the serial link and the flash status outputs of the pair.
module srad_assertions (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_drv,
  input wire logic miso_oe,
  input wire logic BUSY,
  input wire logic WRITE_ENABLE_LATCH
);
  // Longest self-timed cycle in the bench, with margin.
  localparam int BUSY_MAX = 1100;
  logic [10:0] busy_cyc_q;

  // Cycles spent busy so far; it saturates so a stuck flag cannot wrap back under the bound.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_cyc_q <= 11'h000;
    end else if (!BUSY) begin
      busy_cyc_q <= 11'h000;
    end else if (busy_cyc_q != 11'h7FF) begin
      busy_cyc_q <= busy_cyc_q + 11'h001;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  // Both ends must come out of reset quiet and deselected.
  a_reset_quiet: assert property ($rose(RESET_N) |-> cs_n && !sclk && !miso_oe && !BUSY)
    else $error("link not idle after reset");
  // The device may only drive its output inside a frame.
  a_drive_in_frame: assert property (miso_oe |-> !cs_n)
    else $error("output driven while deselected");
  // The serial clock rests low between frames.
  a_sclk_rests: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  // Input data must not move while the device samples on the high phase.
  a_mosi_held: assert property (sclk |-> $stable(mosi))
    else $error("input data moved during high clock phase");
  // Output data changes only in the low clock phase.
  a_out_on_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso_drv) |-> !sclk)
    else $error("output data changed with clock high");
  // A self-timed cycle only starts once select is high again.
  a_busy_after_cs: assert property ($rose(BUSY) |-> cs_n)
    else $error("busy rose inside a frame");
  // Busy holds for a while and then ends within the bench bound.
  a_busy_holds: assert property ($rose(BUSY) |-> BUSY[*8])
    else $error("busy dropped too early");
  a_busy_ends: assert property (busy_cyc_q <= BUSY_MAX)
    else $error("busy lasted beyond the bench bound");
  // The latch clears when the cycle finishes.
  a_latch_cleared: assert property ($fell(BUSY) |-> !WRITE_ENABLE_LATCH)
    else $error("write enable still set after cycle");
  // The latch is only set by a completed frame.
  a_latch_on_cs: assert property ($rose(WRITE_ENABLE_LATCH) |-> cs_n)
    else $error("write enable set inside a frame");

  cover property ($rose(BUSY));
  cover property ($fell(WRITE_ENABLE_LATCH));
  cover property (miso_oe && !miso_drv);
endmodule : srad_assertions

/* test/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] lock_set = 4'h0;
  logic [31:0] hrdata;
  logic hrdy;
  logic hresp;
  logic irq;
  logic busy;
  logic write_enable_latch;
  logic [3:0] locks;
  int oe_cyc = 0;
  int oe_base = 0;
  logic [7:0] rx_b [8];
  logic [7:0] r;
  logic [31:0] d;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Rows: middle address byte, offset, expected byte.
  logic [23:0] rows [7] = '{24'h10FEA5, 24'h10FF3C, 24'h10000F, 24'h1001FF,
    24'h2000FF, 24'h00FEFF, 24'h1100FF};

  srad_spi_if spi ();

  always #2.5 clk = ~clk;

  srad_host #(.PUW_CYC(40)) srad_host_inst (.CORE_CLK(clk), .RESET_N(rst_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .IRQ(irq),
    .SPI(spi.host));
  // Short counts keep the run small; busy bounds follow from them.
  srad_device #(.PUW_CYC(20), .ERASE_CYC(1000), .PROG_CYC(200)) srad_device_inst (
    .CORE_CLK(clk), .RESET_N(rst_n), .SPI(spi.device), .LOCK_SET(lock_set), .BUSY(busy),
    .WRITE_ENABLE_LATCH(write_enable_latch), .LOCK_BITS(locks));
  srad_assertions srad_assertions_inst (.CORE_CLK(clk), .RESET_N(rst_n), .cs_n(spi.cs_n),
    .sclk(spi.sclk), .mosi(spi.mosi), .miso_drv(spi.miso_drv), .miso_oe(spi.miso_oe),
    .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch));

  task automatic wrap_up();
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One single-word transfer; read data is taken at the data phase end.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Sends one byte, waits for the done interrupt, fetches and clears.
  task automatic sbyte(input logic [7:0] b, input logic last, output logic [7:0] rb);
    logic [31:0] t;
    ahb(1'b1, srad_pkg::OFS_TX, {23'h0, last, b}, t);
    while (irq !== 1'b1) @(posedge clk);
    ahb(1'b0, srad_pkg::OFS_RX, 32'h0, t);
    rb = t[7:0];
    ahb(1'b1, srad_pkg::OFS_IRQ_STAT, 32'h1, t);
  endtask : sbyte

  task automatic frame(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      sbyte(v[63-8*i -: 8], i == n - 1, rx_b[i]);
    end
  endtask : frame

  // Write-type command always preceded by its own enable frame.
  task automatic op(input logic [63:0] v, input int n);
    frame({srad_pkg::CMD_WREN, 56'h0}, 1);
    frame(v, n);
  endtask : op

  task automatic rd1(input logic [15:0] a, output logic [7:0] rb);
    frame({srad_pkg::CMD_READ, 8'h00, a, 16'h0, 16'h0}, 6);
    rb = rx_b[5];
  endtask : rd1

  // Counts cycles in which the flash drives its output line; one process owns the count.
  always @(posedge clk) begin
    if (spi.miso_oe === 1'b1) oe_cyc++;
  end

  // Cuts a hang short well above the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    ahb(1'b1, srad_pkg::OFS_IRQ_MASK, 32'h1, d);
    ahb(1'b1, srad_pkg::OFS_TX, {24'h0, srad_pkg::CMD_WREN}, d);
    ahb(1'b0, srad_pkg::OFS_IRQ_STAT, 32'h0, d);
    check("early enable refused", d[1:0], 2'h2);
    check("masked irq", irq, 1'b0);
    ahb(1'b1, srad_pkg::OFS_IRQ_STAT, 32'h2, d);
    ahb(1'b0, 8'h40, 32'h0, d);
    check("unmapped read", d, 32'h0);
    check("response", hresp, 1'b0);
    repeat (60) @(posedge clk);
    ahb(1'b0, srad_pkg::OFS_STATUS, 32'h0, d);
    check("status idle", d, 32'h6);
    // Program across the end of register 1 so the offset wraps.
    op({srad_pkg::CMD_PROG, 8'h00, 8'h10, 8'hFE, 8'hA5, 8'h3C, 8'h0F, 8'h00}, 7);
    check("program busy", busy, 1'b1);
    while (busy !== 1'b0) @(posedge clk);
    check("enable after program", write_enable_latch, 1'b0);
    foreach (rows[i]) begin
      rd1(rows[i][23:8], r);
      check("row byte", r, rows[i][7:0]);
    end
    // A streaming read wraps from the last offset to the first.
    frame({srad_pkg::CMD_READ, 8'h00, 8'h10, 8'hFF, 32'h0}, 8);
    check("wrap 0", rx_b[5], 8'h3C);
    check("wrap 1", rx_b[6], 8'h0F);
    check("wrap 2", rx_b[7], 8'hFF);
    // Select rising one byte late must discard the erase.
    op({srad_pkg::CMD_ERASE, 8'h00, 8'h20, 8'h00, 8'h00, 24'h0}, 5);
    repeat (4) @(posedge clk);
    check("late select busy", busy, 1'b0);
    check("late select enable", write_enable_latch, 1'b1);
    op({srad_pkg::CMD_ERASE, 8'h00, 8'h10, 8'h00, 32'h0}, 4);
    check("erase busy", busy, 1'b1);
    frame({srad_pkg::CMD_RDSR, 56'h0}, 2);
    check("status in erase", rx_b[1][1:0], 2'h3);
    oe_base = oe_cyc;
    rd1(16'h10FE, r);
    check("read in erase", r, 8'hFF);
    check("no drive in erase", oe_cyc - oe_base, 32'h0);
    while (busy !== 1'b0) @(posedge clk);
    check("enable after erase", write_enable_latch, 1'b0);
    rd1(16'h10FE, r);
    check("erased byte", r, 8'hFF);
    @(posedge clk);
    lock_set <= 4'h2;
    op({srad_pkg::CMD_PROG, 8'h00, 8'h10, 8'h00, 8'h55, 24'h0}, 5);
    check("lock bits", locks, 4'h2);
    check("locked busy", busy, 1'b0);
    rd1(16'h1000, r);
    check("locked byte", r, 8'hFF);
    // A second reset in mid-run must bring everything back to idle.
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    check("reset select", spi.cs_n, 1'b1);
    check("reset busy", busy, 1'b0);
    check("reset enable", write_enable_latch, 1'b0);
    check("reset irq", irq, 1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    // After release the power-up wait starts again, so an early enable is refused.
    repeat (2) @(posedge clk);
    check("release busy", busy, 1'b0);
    ahb(1'b0, srad_pkg::OFS_STATUS, 32'h0, d);
    check("release status", d, 32'h4);
    ahb(1'b1, srad_pkg::OFS_TX, {24'h0, srad_pkg::CMD_WREN}, d);
    ahb(1'b0, srad_pkg::OFS_IRQ_STAT, 32'h0, d);
    check("early enable again", d[1:0], 2'h2);
    wrap_up();
  end
endmodule : testbench
